/* File: src/cskip_pkg.sv */
// Constants, types and helper functions of the complement/compare-skip core
package cskip_pkg;
    // Opcode fields of the two decoded instructions
    localparam logic [5:0] OP_COMPLEMENT = 6'h07;
    localparam logic [6:0] OP_COMPARE_SKIP = 7'h31;
    localparam int OP_DEST_BIT = 9;
    localparam int OP_ACCESS_BIT = 8;
    // Register port map, word addresses
    localparam int REG_ADDR_W = 3;
    localparam logic [2:0] REG_WORK = 3'h0;
    localparam logic [2:0] REG_BANK = 3'h1;
    localparam logic [2:0] REG_STATUS = 3'h2;
    localparam logic [2:0] REG_MEM_ADDR_LO = 3'h3;
    localparam logic [2:0] REG_MEM_ADDR_HI = 3'h4;
    localparam logic [2:0] REG_MEM_DATA = 3'h5;
    // Status field positions
    localparam int STAT_ZERO_BIT = 0;
    localparam int STAT_NEG_BIT = 1;
    localparam int STAT_SKIP_BIT = 2;
    // Reset values
    localparam logic [7:0] WORK_RST = 8'h00;
    localparam logic [3:0] BANK_RST = 4'h0;
    localparam logic [1:0] FLAGS_RST = 2'h0;
    // Access bank: low part from bank 0, high part from the top bank
    localparam logic [7:0] ACCESS_SPLIT = 8'h80;
    localparam logic [3:0] ACCESS_HI_BANK = 4'hF;
    localparam logic [3:0] ACCESS_LO_BANK = 4'h0;
    // Two-word instruction prefixes
    localparam logic [3:0] TW_MOVE_PFX = 4'hC;
    localparam logic [6:0] TW_CALL_PFX = 7'h76;
    localparam logic [7:0] TW_GOTO_PFX = 8'hEF;
    localparam logic [7:0] TW_LOADPTR_PFX = 8'hEE;

    typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} q_phase_e;

    // Data memory address from access bit, bank select and file address
    function automatic logic [11:0] data_addr(input logic acc,
                                              input logic [3:0] bank,
                                              input logic [7:0] f);
        logic [3:0] b;
        b = bank;
        if (!acc) begin
            b = (f >= ACCESS_SPLIT) ? ACCESS_HI_BANK : ACCESS_LO_BANK;
        end
        return {b, f};
    endfunction

    // True when a word opens an instruction of two program words
    function automatic logic two_word(input logic [15:0] w);
        return (w[15:12] == TW_MOVE_PFX) || (w[15:9] == TW_CALL_PFX) ||
               (w[15:8] == TW_GOTO_PFX) || (w[15:8] == TW_LOADPTR_PFX);
    endfunction
endpackage

/* File: src/cskip_exec.sv */
// Decode and arithmetic of the complement and compare-skip instructions
`timescale 1ns/10ps
module cskip_exec (
    input wire logic [15:0] instr,
    input wire logic nop_slot,
    input wire logic [3:0] bank,
    input wire logic [7:0] operand,
    input wire logic [7:0] work,
    output logic is_complement,
    output logic is_compare,
    output logic to_file,
    output logic [11:0] addr,
    output logic [7:0] result,
    output logic equal,
    output logic neg,
    output logic zero
);
    wire logic [7:0] diff;

    assign is_complement = !nop_slot &&
        (instr[15:10] == cskip_pkg::OP_COMPLEMENT);
    assign is_compare = !nop_slot &&
        (instr[15:9] == cskip_pkg::OP_COMPARE_SKIP);
    // Cleared destination bit sends the result to the working register
    assign to_file = instr[cskip_pkg::OP_DEST_BIT];
    assign addr = cskip_pkg::data_addr(instr[cskip_pkg::OP_ACCESS_BIT],
                                       bank, instr[7:0]);
    assign result = ~operand;
    // Unsigned difference; only its zero-ness matters
    assign diff = operand - work;
    assign equal = (diff == 8'h00);
    assign neg = result[7];
    assign zero = (result == 8'h00);
endmodule // cskip_exec

/* File: src/cskip_core.sv */
// Four-phase core executing file complement and compare-skip-if-equal
// Notes on behaviour
// - Word 000111 d a f decodes as complement; writes inverted file register.
// - Destination bit 0 writes working register, 1 writes the file register.
// - Access bit 0 uses the access bank; 1 takes bank from bank select.
// - Word 0110001 a f decodes as compare-skip-if-equal; no destination bit.
// - Compare subtracts working register from file; stores nothing.
// - On equality the fetched next instruction becomes a no-operation.
// - A skipped two-word instruction costs two no-operation cycles.
`timescale 1ns/10ps
module cskip_core #(
    parameter int MEM_DEPTH = 4096
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [15:0] fetch_word,
    output logic fetch_req,
    output logic nop_cycle,
    output logic [1:0] phase,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata
);
    logic [7:0] data_mem [MEM_DEPTH];

    cskip_pkg::q_phase_e phase_ff;
    cskip_pkg::q_phase_e nxt_phase;
    logic [15:0] instr_ff;
    logic nop_ff;
    logic skip_ff;
    logic [7:0] operand_ff;
    logic [7:0] work_ff;
    logic [3:0] bank_ff;
    logic neg_ff;
    logic zero_ff;
    logic [11:0] mem_ptr_ff;
    logic fetch_req_ff;
    logic [7:0] rdata_ff;

    wire logic is_comp;
    wire logic is_cmp;
    wire logic to_file;
    wire logic [11:0] op_addr;
    wire logic [7:0] result;
    wire logic equal;
    wire logic res_neg;
    wire logic res_zero;

    cskip_exec u_exec (
        .instr(instr_ff),
        .nop_slot(nop_ff),
        .bank(bank_ff),
        .operand(operand_ff),
        .work(work_ff),
        .is_complement(is_comp),
        .is_compare(is_cmp),
        .to_file(to_file),
        .addr(op_addr),
        .result(result),
        .equal(equal),
        .neg(res_neg),
        .zero(res_zero)
    );

    // Phase decode and write qualifiers
    wire logic at_q1 = (phase_ff == cskip_pkg::PH_Q1);
    wire logic at_q2 = (phase_ff == cskip_pkg::PH_Q2);
    wire logic at_q4 = (phase_ff == cskip_pkg::PH_Q4);
    wire logic core_wr_file = at_q4 && is_comp && to_file;
    wire logic core_wr_work = at_q4 && is_comp && !to_file;
    wire logic core_wr_flags = at_q4 && is_comp;
    wire logic skip_hit = at_q4 && is_cmp && equal;

    // Register port decode
    wire logic wr_work = reg_wr && (reg_addr == cskip_pkg::REG_WORK);
    wire logic wr_bank = reg_wr && (reg_addr == cskip_pkg::REG_BANK);
    wire logic wr_stat = reg_wr && (reg_addr == cskip_pkg::REG_STATUS);
    wire logic wr_plo = reg_wr && (reg_addr == cskip_pkg::REG_MEM_ADDR_LO);
    wire logic wr_phi = reg_wr && (reg_addr == cskip_pkg::REG_MEM_ADDR_HI);
    wire logic wr_mdat = reg_wr && (reg_addr == cskip_pkg::REG_MEM_DATA);
    // Core write wins a collision on the data memory port
    wire logic bus_mem_wr = wr_mdat && !core_wr_file;

    wire logic [7:0] status_view = {5'h00, skip_ff, neg_ff, zero_ff};
    logic [7:0] rd_mux;
    always_comb begin
        case (reg_addr)
            cskip_pkg::REG_WORK: rd_mux = work_ff;
            cskip_pkg::REG_BANK: rd_mux = {4'h0, bank_ff};
            cskip_pkg::REG_STATUS: rd_mux = status_view;
            cskip_pkg::REG_MEM_ADDR_LO: rd_mux = mem_ptr_ff[7:0];
            cskip_pkg::REG_MEM_ADDR_HI: rd_mux = {4'h0, mem_ptr_ff[11:8]};
            cskip_pkg::REG_MEM_DATA: rd_mux = data_mem[mem_ptr_ff];
            default: rd_mux = 8'h00;
        endcase
    end

    always_comb begin
        case (phase_ff)
            cskip_pkg::PH_Q1: nxt_phase = cskip_pkg::PH_Q2;
            cskip_pkg::PH_Q2: nxt_phase = cskip_pkg::PH_Q3;
            cskip_pkg::PH_Q3: nxt_phase = cskip_pkg::PH_Q4;
            default: nxt_phase = cskip_pkg::PH_Q1;
        endcase
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            phase_ff <= cskip_pkg::PH_Q1;
            fetch_req_ff <= 1'b0;
        end else begin
            phase_ff <= nxt_phase;
            // Ask for the next word one phase before it is latched
            fetch_req_ff <= (nxt_phase == cskip_pkg::PH_Q4);
        end
    end

    // Instruction latch; a pending skip turns the fetched word into a nop
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            instr_ff <= 16'h0000;
            nop_ff <= 1'b1;
            skip_ff <= 1'b0;
        end else if (at_q1) begin
            instr_ff <= fetch_word;
            nop_ff <= skip_ff;
            // Only the first skipped word may stretch the skip; caps it at two
            skip_ff <= skip_ff && !nop_ff &&
                cskip_pkg::two_word(fetch_word);
        end else if (skip_hit) begin
            skip_ff <= 1'b1;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            operand_ff <= 8'h00;
        end else if (at_q2) begin
            operand_ff <= data_mem[op_addr];
        end
    end

    always_ff @(posedge mclk) begin
        if (core_wr_file) begin
            data_mem[op_addr] <= result;
        end else if (bus_mem_wr) begin
            data_mem[mem_ptr_ff] <= reg_wdata;
        end
    end

    // Compare writes nothing: only the complement reaches these
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            work_ff <= cskip_pkg::WORK_RST;
            bank_ff <= cskip_pkg::BANK_RST;
            {neg_ff, zero_ff} <= cskip_pkg::FLAGS_RST;
        end else begin
            if (core_wr_work) begin
                work_ff <= result;
            end else if (wr_work) begin
                work_ff <= reg_wdata;
            end
            if (wr_bank) begin
                bank_ff <= reg_wdata[3:0];
            end
            if (core_wr_flags) begin
                {neg_ff, zero_ff} <= {res_neg, res_zero};
            end else if (wr_stat) begin
                neg_ff <= reg_wdata[cskip_pkg::STAT_NEG_BIT];
                zero_ff <= reg_wdata[cskip_pkg::STAT_ZERO_BIT];
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            mem_ptr_ff <= 12'h000;
        end else if (wr_plo) begin
            mem_ptr_ff[7:0] <= reg_wdata;
        end else if (wr_phi) begin
            mem_ptr_ff[11:8] <= reg_wdata[3:0];
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rdata_ff <= 8'h00;
        end else if (reg_rd) begin
            rdata_ff <= rd_mux;
        end else begin
            rdata_ff <= 8'h00;
        end
    end

    assign fetch_req = fetch_req_ff;
    assign nop_cycle = nop_ff;
    assign phase = phase_ff;
    assign reg_rdata = rdata_ff;
endmodule // cskip_core

/* File: test/cskip_core_monitor.sv */
// Port checker for the complement and compare-skip core
`timescale 1ns/10ps
module cskip_core_monitor (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [15:0] fetch_word,
    input wire logic fetch_req,
    input wire logic nop_cycle,
    input wire logic [1:0] phase
);
    logic [15:0] cur_ff;
    logic [15:0] prev_ff;
    wire tw = prev_ff[15:12] == cskip_pkg::TW_MOVE_PFX ||
        prev_ff[15:9] == cskip_pkg::TW_CALL_PFX ||
        prev_ff[15:8] == cskip_pkg::TW_GOTO_PFX ||
        prev_ff[15:8] == cskip_pkg::TW_LOADPTR_PFX;
    // Words latched in the last two slots
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cur_ff <= 16'h0000;
            prev_ff <= 16'h0000;
        end else if (phase == 2'h0) begin
            cur_ff <= fetch_word;
            prev_ff <= cur_ff;
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    AST_PHASE_STEP: assert property (!$past(rst) |->
        phase == 2'($past(phase) + 2'h1))
        else $error("phase did not advance");
    AST_FETCH_Q4: assert property (fetch_req == (phase == 2'h3))
        else $error("fetch request outside Q4");
    AST_NOP_CAUSE: assert property ($rose(nop_cycle) |->
        prev_ff[15:9] == cskip_pkg::OP_COMPARE_SKIP) else $error("stray skip");
    AST_NOP_START: assert property ($rose(nop_cycle) |-> phase == 2'h1)
        else $error("skip slot misaligned");
    AST_NOP_LEN: assert property ($rose(nop_cycle) |-> nop_cycle[*4])
        else $error("skip slot too short");
    AST_NOP_HOLD: assert property (phase != 2'h1 |-> $stable(nop_cycle))
        else $error("skip flag changed mid slot");
    AST_TWO_WORD: assert property (nop_cycle && phase == 2'h1 &&
        $past(nop_cycle, 4) |-> tw) else $error("second skip slot unjustified");
    AST_NOP_MAX: assert property (nop_cycle && phase == 2'h1 &&
        $past(nop_cycle, 4) |-> !$past(nop_cycle, 8))
        else $error("more than two skip slots");
    cover property ($rose(nop_cycle));
    cover property (nop_cycle && phase == 2'h1 && $past(nop_cycle, 4));
    cover property (fetch_req && fetch_word[15:10] == cskip_pkg::OP_COMPLEMENT);
endmodule // cskip_core_monitor

bind cskip_core cskip_core_monitor u_mon (.mclk(mclk), .rst(rst),
    .fetch_word(fetch_word), .fetch_req(fetch_req),
    .nop_cycle(nop_cycle), .phase(phase));

/* File: test/tb_complement_and_compare_skip_exec.sv */
// Self-checking bench for the complement and compare-skip core
`timescale 1ns/10ps
module tb_complement_and_compare_skip_exec;
    typedef struct {
        logic [15:0] w;
        logic [11:0] adr;
        logic [7:0] bk, wk, f, ef, ew, es, en;
    } row_s;
    logic mclk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic fetch_req, nop_cycle;
    logic [15:0] fetch_word = 16'h0000;
    logic [1:0] phase;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00, reg_rdata, got, n0;
    logic [7:0] nop_slots = 8'h00;
    logic [15:0] prog[$];
    int error_cnt = 0, checks_done = 0, cycles = 0;
    row_s rows[5] = '{
        '{16'h1C10, 12'h010, 8'h01, 8'h5A, 8'h13, 8'h13, 8'hEC, 8'h02, 8'h00},
        '{16'h1F10, 12'h210, 8'h02, 8'h5A, 8'hFF, 8'h00, 8'h5A, 8'h01, 8'h00},
        '{16'h1E90, 12'hF90, 8'h02, 8'h5A, 8'h7F, 8'h80, 8'h5A, 8'h02, 8'h00},
        '{16'h6220, 12'h020, 8'h02, 8'h55, 8'h55, 8'h55, 8'h55, 8'h03, 8'h01},
        '{16'h6320, 12'h320, 8'h03, 8'h55, 8'h54, 8'h54, 8'h55, 8'h03, 8'h00}};
    cskip_core DUT (.mclk(mclk), .rst(rst), .fetch_word(fetch_word),
        .fetch_req(fetch_req), .nop_cycle(nop_cycle), .phase(phase),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    initial begin
        forever #50 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cycles++;
        if (fetch_req === 1'b1)
            fetch_word <= (prog.size() > 0) ? prog.pop_front() : 16'h0000;
        if (phase === 2'h2 && nop_cycle === 1'b1)
            nop_slots <= nop_slots + 8'h01;
        if (cycles == 3000) begin
            error_cnt++;
            summarize();
        end
    end
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(logic [2:0] a, logic [7:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(logic [2:0] a);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 got = reg_rdata;
    endtask
    task automatic run();
        while (prog.size() > 0) @(posedge mclk);
        repeat (6) @(posedge mclk);
    endtask
    initial begin
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        wr(3'h6, 8'hFF);
        rd(3'h6);
        chk("unmapped read", 8'h00, got);
        foreach (rows[i]) begin
            wr(3'h1, rows[i].bk);
            wr(3'h0, rows[i].wk);
            wr(3'h2, 8'h03);
            wr(3'h3, rows[i].adr[7:0]);
            wr(3'h4, {4'h0, rows[i].adr[11:8]});
            wr(3'h5, rows[i].f);
            n0 = nop_slots;
            prog = '{rows[i].w, 16'h0000};
            run();
            chk("skip slots", rows[i].en, nop_slots - n0);
            rd(3'h0);
            chk("work", rows[i].ew, got);
            rd(3'h2);
            chk("flags", rows[i].es, got & 8'h03);
            rd(3'h5);
            chk("file", rows[i].ef, got);
            $display("row %0d done", i);
        end
        // Skipped complement must not land; two-word skip costs two slots
        wr(3'h3, 8'h20);
        wr(3'h4, 8'h00);
        n0 = nop_slots;
        prog = '{16'h6220, 16'h1C20, 16'h6220, 16'hEF00, 16'hF000, 16'h0000};
        run();
        chk("long skip slots", 8'h03, nop_slots - n0);
        rd(3'h0);
        chk("work after skip", 8'h55, got);
        $display("skip sequence done");
        @(posedge mclk);
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        rd(3'h2);
        chk("flags after reset", 8'h00, got);
        $display("reset test done");
        summarize();
    end
endmodule // tb_complement_and_compare_skip_exec
